// *** include/lpm_pkg.sv ***
package lpm_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL_ZERO = 5'h00;
  localparam logic [4:0] OFS_STATUS    = 5'h04;
  localparam logic [4:0] OFS_ANA_CTRL  = 5'h08;
  localparam logic [4:0] OFS_ANA_CFG   = 5'h0C;
  localparam logic [4:0] OFS_MODE      = 5'h10;
  localparam logic [4:0] OFS_DEBUG     = 5'h14;

  // Field positions
  localparam int TSEL_LSB   = 5;
  localparam int ST_CKF     = 0;
  localparam int ST_STBY    = 1;
  localparam int ST_WUF     = 2;
  localparam int MD_LEVEL   = 0;
  localparam int MD_FAST    = 1;
  localparam int MD_LSI     = 2;
  localparam int MD_WAKEPIN = 3;
  localparam int MD_WDGKEY  = 4;
  localparam int AC_SRAM4   = 19;
  localparam int AC_SRAM32  = 18;
  localparam int AC_FLASH   = 17;
  localparam int AC_PORBG   = 16;
  localparam int AC_BG_LSB  = 14;
  localparam int AC_REGULP  = 2;

  // Target selector codes
  localparam logic [1:0] TSEL_STOP    = 2'h0;
  localparam logic [1:0] TSEL_STANDBY = 2'h2;

  // Stop level patterns
  localparam logic [19:0] PAT3_CTRL = 20'h63004;
  localparam logic [9:0]  PAT3_CFG  = 10'h3BF;
  localparam logic [19:0] PAT4_CTRL = 20'h7B004;
  localparam logic [9:0]  PAT4_CFG  = 10'h3B3;
  localparam logic [1:0]  BG_OFF    = 2'h2;

  // Reset values
  localparam logic [1:0] RST_TSEL = 2'h0;
  localparam logic [1:0] RST_DBG  = 2'h0;

  // Regulator modes and clock selects
  localparam logic [1:0] REG_NORMAL = 2'h0;
  localparam logic [1:0] REG_ULP    = 2'h2;
  localparam logic [1:0] SEL_MED    = 2'h0;

  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int OSC_START_NS = 2000;
  localparam int REG_RECOV_NS = 1000;
  localparam int BG_RECOV_NS  = 3000;
  localparam int LP_EXTRA_NS  = 500;
  localparam int OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_RECOV_CYC = (REG_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int BG_RECOV_CYC  = (BG_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int LP_EXTRA_CYC  = (LP_EXTRA_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    S_RUN, S_SLEEP, S_STOP_ENTRY, S_STOP, S_STOP_WAKE, S_STANDBY
  } lpm_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  typedef struct packed {
    logic        wait_interrupt_instr;
    logic        wait_event_instr;
    logic        deep_sleep_request;
    logic        irq_pending;
  } core_req_t;

  typedef struct packed {
    logic        cpu_clk_en;
    logic [1:0]  sysclk_sel;
    logic        clk_cfg_reset;
    logic        sys_reset_req;
    logic        medium_osc_en;
    logic        fast_osc_en;
    logic        lsi_en;
    logic        hs_clk_allow;
    logic        core_on;
    logic [1:0]  reg_mode;
    logic        flash_pd;
    logic        bg_off;
    logic        reset_bandgap_off;
    logic [1:0]  sram_off;
    logic        vdet_off;
    logic [19:0] ana_ctrl;
    logic [9:0]  ana_cfg;
    logic        io_hiz;
    logic        wake_pad_keep;
    logic        tamper_pad_keep;
    logic        debug_link_en;
    logic        watchdog_run;
  } pwr_ctl_t;

  typedef struct packed {
    lpm_state_t  st;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  tsel;
    logic [4:0]  mode;
    logic [1:0]  dbg_cfg;
    logic        clock_restore_flag;
    logic        stby;
    logic        wakeup_flag;
    logic        via_wfi;
    logic        lp_reg;
    logic [11:0] cnt;
    logic        wake_prev;
    logic        alarm_prev;
    pwr_ctl_t    ctl;
  } lpm_regs_t;

endpackage : lpm_pkg

// *** design/low_power_mode_controller.sv ***
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module low_power_mode_controller (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire lpm_pkg::avs_req_t  avs_req,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire lpm_pkg::core_req_t core_req,
  input  wire logic [19:0]        evt_lines,
  input  wire logic [19:0]        evt_pending,
  input  wire logic [19:0]        evt_irq_mode,
  input  wire logic [19:0]        evt_evt_mode,
  input  wire logic [19:0]        irq_vector_en,
  input  wire logic               rtc_alarm_flag,
  input  wire logic               rtc_alarm,
  input  wire logic               wake_pin,
  input  wire logic               external_reset_pin_n,
  input  wire logic               watchdog_reset,
  input  wire logic               watchdog_hw_start,
  input  wire logic               tamper_cfg,
  input  wire logic               flash_busy,
  input  wire logic               apb_busy,
  input  wire logic               osc_ready,
  input  wire logic               reg_ready,
  output lpm_pkg::pwr_ctl_t       pwr_ctl
);
  import lpm_pkg::*;

  lpm_regs_t q;
  lpm_regs_t d;

  function automatic logic [11:0] wake_delay(input logic bg_was_off, input logic reg_lp);
    int sum;
    sum = OSC_START_CYC + REG_RECOV_CYC;
    if (bg_was_off) begin
      sum = sum + BG_RECOV_CYC;
    end
    if (reg_lp) begin
      sum = sum + LP_EXTRA_CYC;
    end
    return sum[11:0];
  endfunction : wake_delay

  function automatic pwr_ctl_t run_ctl(input pwr_ctl_t c, input logic fast, input logic low_speed_internal_osc);
    pwr_ctl_t r;
    r = c;
    r.cpu_clk_en    = 1'b1;
    r.medium_osc_en = 1'b1;
    r.fast_osc_en   = fast;
    r.lsi_en        = low_speed_internal_osc;
    r.hs_clk_allow  = 1'b1;
    r.core_on       = 1'b1;
    r.reg_mode      = REG_NORMAL;
    r.flash_pd      = 1'b0;
    r.bg_off        = 1'b0;
    r.reset_bandgap_off    = 1'b0;
    r.sram_off      = 2'h0;
    r.vdet_off      = 1'b0;
    r.ana_ctrl      = 20'h00000;
    r.ana_cfg       = 10'h000;
    r.io_hiz        = 1'b0;
    r.wake_pad_keep = 1'b0;
    r.tamper_pad_keep = 1'b0;
    r.debug_link_en = 1'b1;
    return r;
  endfunction : run_ctl

  logic        bus_req;
  logic        bus_ack;
  logic        sleep_cmd;
  logic        stop_block;
  logic        stop_wake;
  logic        stby_wake;
  logic [19:0] pat_ctrl;
  logic [9:0]  pat_cfg;
  logic [31:0] rd_mux;

  assign bus_req = avs_req.read | avs_req.write;
  assign bus_ack = bus_req & ~q.waitreq;
  assign sleep_cmd = core_req.wait_interrupt_instr | core_req.wait_event_instr;
  assign stop_block = (|evt_pending) | rtc_alarm_flag;
  // Event line 17 carries the alarm once software routes it
  assign stop_wake = q.via_wfi ? |(evt_lines & evt_irq_mode & irq_vector_en)
                               : |(evt_lines & evt_evt_mode);
  assign stby_wake = (wake_pin & ~q.wake_prev) | (rtc_alarm & ~q.alarm_prev)
                   | ~external_reset_pin_n | watchdog_reset;
  assign pat_ctrl = q.mode[MD_LEVEL] ? PAT4_CTRL : PAT3_CTRL;
  assign pat_cfg  = q.mode[MD_LEVEL] ? PAT4_CFG : PAT3_CFG;

  always_comb begin
    case (avs_req.address)
      OFS_CTRL_ZERO: rd_mux = {25'h0, q.tsel, 5'h00};
      OFS_STATUS:    rd_mux = {29'h0, q.wakeup_flag, q.stby, q.clock_restore_flag};
      OFS_ANA_CTRL:  rd_mux = {12'h000, q.ctl.ana_ctrl};
      OFS_ANA_CFG:   rd_mux = {22'h0, q.ctl.ana_cfg};
      OFS_MODE:      rd_mux = {27'h0, q.ctl.watchdog_run, q.mode[3:0]};
      OFS_DEBUG:     rd_mux = {30'h0, q.dbg_cfg};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    d = q;
    d.ctl.clk_cfg_reset = 1'b0;
    d.ctl.sys_reset_req = 1'b0;
    d.wake_prev  = wake_pin;
    d.alarm_prev = rtc_alarm;
    d.mode[MD_WDGKEY] = 1'b0;
    // Bus slave: one wait cycle, then answer with waitrequest low
    d.waitreq = ~(bus_req & q.waitreq);
    if (bus_req & q.waitreq) begin
      d.rdata = rd_mux;
    end
    if (bus_ack && avs_req.write && avs_req.byteenable[0]) begin
      case (avs_req.address)
        OFS_CTRL_ZERO: d.tsel = avs_req.writedata[TSEL_LSB +: 2];
        OFS_STATUS: begin
          d.clock_restore_flag  = q.clock_restore_flag & ~avs_req.writedata[ST_CKF];
          d.stby = q.stby & ~avs_req.writedata[ST_STBY];
          d.wakeup_flag  = q.wakeup_flag & ~avs_req.writedata[ST_WUF];
        end
        OFS_MODE: begin
          d.mode = avs_req.writedata[4:0];
          d.ctl.fast_osc_en = avs_req.writedata[MD_FAST] & q.ctl.hs_clk_allow;
          d.ctl.lsi_en = avs_req.writedata[MD_LSI];
        end
        OFS_DEBUG: d.dbg_cfg = avs_req.writedata[1:0];
        default: d.tsel = q.tsel;
      endcase
    end
    if (d.mode[MD_WDGKEY] | watchdog_hw_start) begin
      d.ctl.watchdog_run = 1'b1;
    end
    case (q.st)
      S_RUN: begin
        if (sleep_cmd) begin
          d.via_wfi = core_req.wait_interrupt_instr;
          d.ctl.cpu_clk_en = 1'b0;
          if (!core_req.deep_sleep_request) begin
            d.st = S_SLEEP;
          end else if (q.tsel == TSEL_STOP) begin
            if (stop_block) begin
              d.ctl.cpu_clk_en = 1'b1;
              d.clock_restore_flag = 1'b1;
            end else begin
              d.st = S_STOP_ENTRY;
            end
          end else if (q.tsel == TSEL_STANDBY) begin
            if (q.wakeup_flag) begin
              d.ctl.cpu_clk_en = 1'b1;
            end else begin
              d.st = S_STANDBY;
              d.ctl.medium_osc_en = 1'b0;
              d.ctl.fast_osc_en = 1'b0;
              d.ctl.hs_clk_allow = 1'b0;
              d.ctl.core_on = 1'b0;
              d.ctl.reg_mode = REG_ULP;
              d.ctl.flash_pd = 1'b1;
              d.ctl.bg_off = 1'b1;
              d.ctl.reset_bandgap_off = 1'b1;
              d.ctl.sram_off = 2'h3;
              d.ctl.vdet_off = 1'b1;
              d.ctl.io_hiz = 1'b1;
              d.ctl.wake_pad_keep = q.mode[MD_WAKEPIN];
              d.ctl.tamper_pad_keep = tamper_cfg;
              d.ctl.debug_link_en = q.dbg_cfg[1];
            end
          end else begin
            d.st = S_SLEEP;
          end
        end
      end
      S_SLEEP: begin
        if (core_req.irq_pending | (|(evt_lines & evt_evt_mode))) begin
          d.st = S_RUN;
          d.ctl.cpu_clk_en = 1'b1;
        end
      end
      S_STOP_ENTRY: begin
        if (stop_block) begin
          d.st = S_RUN;
          d.ctl.cpu_clk_en = 1'b1;
          d.clock_restore_flag = 1'b1;
        end else if (!flash_busy && !apb_busy) begin
          d.st = S_STOP;
          d.ctl.medium_osc_en = 1'b0;
          d.ctl.fast_osc_en = 1'b0;
          d.ctl.hs_clk_allow = 1'b0;
          d.ctl.ana_ctrl = pat_ctrl;
          d.ctl.ana_cfg = pat_cfg;
          d.ctl.reg_mode = pat_ctrl[AC_REGULP] ? REG_ULP : REG_NORMAL;
          d.ctl.flash_pd = pat_ctrl[AC_FLASH];
          d.ctl.bg_off = (pat_ctrl[AC_BG_LSB +: 2] == BG_OFF);
          d.ctl.reset_bandgap_off = pat_ctrl[AC_PORBG];
          d.ctl.sram_off = {pat_ctrl[AC_SRAM4], pat_ctrl[AC_SRAM32]};
          d.lp_reg = pat_ctrl[AC_REGULP];
          d.ctl.debug_link_en = q.dbg_cfg[0];
        end
      end
      S_STOP: begin
        if (stop_wake) begin
          d.st = S_STOP_WAKE;
          d.cnt = wake_delay(q.ctl.bg_off, q.lp_reg);
          d.ctl.medium_osc_en = 1'b1;
          d.ctl.reg_mode = REG_NORMAL;
          d.ctl.bg_off = 1'b0;
        end
      end
      S_STOP_WAKE: begin
        if (q.cnt != 12'h000) begin
          d.cnt = q.cnt - 12'h001;
        end else if (osc_ready && reg_ready) begin
          d.st = S_RUN;
          d.ctl = run_ctl(q.ctl, 1'b0, q.mode[MD_LSI]);
          d.mode[MD_FAST] = 1'b0;
          d.ctl.sysclk_sel = SEL_MED;
          d.ctl.clk_cfg_reset = 1'b1;
          d.clock_restore_flag = 1'b1;
        end
      end
      S_STANDBY: begin
        if (stby_wake) begin
          d.st = S_RUN;
          d.ctl = run_ctl(q.ctl, 1'b0, q.mode[MD_LSI]);
          d.mode[MD_FAST] = 1'b0;
          d.ctl.sysclk_sel = SEL_MED;
          d.ctl.sys_reset_req = 1'b1;
          d.stby = 1'b1;
          d.wakeup_flag = 1'b1;
        end
      end
      default: d.st = S_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= S_RUN;
      q.waitreq <= 1'b1;
      q.tsel <= RST_TSEL;
      q.dbg_cfg <= RST_DBG;
      q.ctl.cpu_clk_en <= 1'b1;
      q.ctl.sysclk_sel <= SEL_MED;
      q.ctl.medium_osc_en <= 1'b1;
      q.ctl.hs_clk_allow <= 1'b1;
      q.ctl.core_on <= 1'b1;
      q.ctl.reg_mode <= REG_NORMAL;
      q.ctl.debug_link_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign pwr_ctl         = q.ctl;

  abort_entry_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_RUN && sleep_cmd && core_req.deep_sleep_request && q.tsel == TSEL_STOP
     && stop_block) |=> (q.st == S_RUN && q.clock_restore_flag && q.ctl.cpu_clk_en))
    else $error("stop entry not aborted");

  stop_gate_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STOP) |-> (!q.ctl.medium_osc_en && !q.ctl.fast_osc_en && !q.ctl.hs_clk_allow
                          && q.ctl.core_on && !q.ctl.cpu_clk_en))
    else $error("stop clock gating wrong");

  level_pattern_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STOP_ENTRY && !stop_block && !flash_busy
     && !apb_busy && q.mode[MD_LEVEL])
    |=> (q.ctl.ana_ctrl == PAT4_CTRL && q.ctl.ana_cfg == PAT4_CFG && q.ctl.bg_off
         && q.ctl.flash_pd && q.ctl.reg_mode == REG_ULP))
    else $error("level four pattern wrong");

  stop_exit_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STOP_WAKE && q.cnt == 12'h000 && osc_ready && reg_ready)
    |=> (q.st == S_RUN && q.ctl.sysclk_sel == SEL_MED && q.ctl.clk_cfg_reset && q.clock_restore_flag)
        ##1 !q.ctl.clk_cfg_reset)
    else $error("stop exit clock restore wrong");

  wake_hold_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STOP && stop_wake) |=> (!q.ctl.cpu_clk_en && q.st == S_STOP_WAKE) [*8])
    else $error("clock released before wake delay");

  standby_state_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STANDBY) |-> (q.ctl.io_hiz && !q.ctl.core_on && q.ctl.reg_mode == REG_ULP
                             && q.ctl.flash_pd && !q.ctl.hs_clk_allow && q.ctl.sram_off == 2'h3))
    else $error("standby power state wrong");

  standby_exit_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STANDBY && wake_pin && !q.wake_prev)
    |=> (q.ctl.sys_reset_req && q.stby && !q.ctl.fast_osc_en) ##1 !q.ctl.sys_reset_req)
    else $error("standby wake wrong");

  watchdog_hold_a: assert property (@(posedge clk) disable iff (rst)
    q.ctl.watchdog_run |=> q.ctl.watchdog_run)
    else $error("watchdog stopped");

  sleep_only_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_SLEEP) |-> (!q.ctl.cpu_clk_en && q.ctl.medium_osc_en && q.ctl.hs_clk_allow
                           && q.ctl.core_on && !q.ctl.flash_pd))
    else $error("sleep gated more than cpu clock");

  debug_link_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_STOP && !q.dbg_cfg[0]) |-> !q.ctl.debug_link_en)
    else $error("debug link kept in stop");

  standby_guard_a: assert property (@(posedge clk) disable iff (rst)
    (q.st == S_RUN && sleep_cmd && core_req.deep_sleep_request
     && q.tsel == TSEL_STANDBY && q.wakeup_flag) |=> q.st == S_RUN)
    else $error("standby entered with wakeup flag set");

endmodule : low_power_mode_controller

`default_nettype wire

// *** tb/core_link_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module core_link_model (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              slow,
  input  wire lpm_pkg::pwr_ctl_t ctl,
  output logic                   osc_ready,
  output logic                   reg_ready
);
  import lpm_pkg::*;
  int unsigned cnt_q;
  // Oscillator and regulator report stable some time after enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= 0;
      osc_ready <= 1'b0;
      reg_ready <= 1'b0;
    end else if (!ctl.medium_osc_en) begin
      cnt_q     <= 0;
      osc_ready <= 1'b0;
      reg_ready <= 1'b0;
    end else begin
      cnt_q     <= cnt_q + 1;
      osc_ready <= cnt_q >= (slow ? 1500 : 2);
      reg_ready <= cnt_q >= (slow ? 1500 : 3);
    end
  end
endmodule : core_link_model
`default_nettype wire

// *** tb/low_power_mode_controller_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module low_power_mode_controller_tb;
  import lpm_pkg::*;
  logic        clk, rst, wreq, alarm_flag, alarm, wpin, rpin_n, wdg_rst;
  logic        tamper, fbusy, osc_rdy, reg_rdy, slow;
  logic [19:0] ev_lines, ev_pend, vec;
  logic [31:0] rdata, q;
  avs_req_t    req;
  core_req_t   core;
  pwr_ctl_t    ctl;
  int          mismatches, n_tests, cfg_cnt, sr_cnt, n, c, lat;

  always #2.5 clk = !clk;

  low_power_mode_controller DUT (.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .core_req(core), .evt_lines(ev_lines), .evt_pending(ev_pend),
    .evt_irq_mode(20'h20008), .evt_evt_mode(20'h20), .irq_vector_en(vec),
    .rtc_alarm_flag(alarm_flag), .rtc_alarm(alarm), .wake_pin(wpin),
    .external_reset_pin_n(rpin_n), .watchdog_reset(wdg_rst), .watchdog_hw_start(1'b0),
    .tamper_cfg(tamper), .flash_busy(fbusy), .apb_busy(1'b0), .osc_ready(osc_rdy),
    .reg_ready(reg_rdy), .pwr_ctl(ctl));

  core_link_model far (.clk(clk), .rst(rst), .slow(slow), .ctl(ctl), .osc_ready(osc_rdy),
    .reg_ready(reg_rdy));

  always @(posedge clk) begin
    if (ctl.clk_cfg_reset === 1'b1) cfg_cnt++;
    if (ctl.sys_reset_req === 1'b1) sr_cnt++;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic pulse(input logic use_wfi);
    @(posedge clk);
    core.wait_interrupt_instr <= use_wfi;
    core.wait_event_instr <= !use_wfi;
    @(posedge clk);
    core.wait_interrupt_instr <= 1'b0;
    core.wait_event_instr <= 1'b0;
  endtask : pulse

  task automatic wait_cpu(input logic v);
    n = 0;
    while (ctl.cpu_clk_en !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK(ctl.cpu_clk_en, v)
  endtask : wait_cpu

  initial begin
    repeat (25000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    clk = 0; rst = 1; req = '0; core = '0; ev_lines = '0; ev_pend = '0; vec = 20'h20008;
    {alarm_flag, alarm, wpin, wdg_rst, tamper, fbusy, slow} = '0; rpin_n = 1;
    mismatches = 0; n_tests = 0; cfg_cnt = 0; sr_cnt = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    `CHK({wreq, ctl.cpu_clk_en, ctl.medium_osc_en, ctl.core_on}, 4'hF)
    `CHK(ctl.reg_mode, REG_NORMAL)
    bus(1'b0, OFS_STATUS, 0);
    `CHK(q, 32'h0)
    bus(1'b0, 5'h1C, 0);
    `CHK(q, 32'h0)
    core.deep_sleep_request <= 1'b1;
    ev_pend <= 20'h4;
    pulse(1'b1);
    repeat (3) @(posedge clk);
    `CHK(ctl.cpu_clk_en, 1'b1)
    ev_pend <= '0;
    fbusy <= 1'b1;
    pulse(1'b0);
    repeat (2) @(posedge clk);
    alarm_flag <= 1'b1;
    wait_cpu(1'b1);
    `CHK(n < 10, 1'b1)
    {fbusy, alarm_flag} <= 2'h0;
    bus(1'b0, OFS_STATUS, 0);
    `CHK(q[ST_CKF], 1'b1)
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_STATUS, 32'h7);
      bus(1'b1, OFS_MODE, 32'(i));
      bus(1'b1, OFS_DEBUG, 32'(i));
      slow <= (i == 0);
      c = cfg_cnt;
      pulse(i == 1);
      wait_cpu(1'b0);
      repeat (3) @(posedge clk);
      `CHK(ctl.ana_ctrl, i ? PAT4_CTRL : PAT3_CTRL)
      `CHK(ctl.ana_cfg, i ? PAT4_CFG : PAT3_CFG)
      `CHK({ctl.medium_osc_en, ctl.fast_osc_en, ctl.hs_clk_allow, ctl.core_on}, 4'h1)
      `CHK(ctl.debug_link_en, i[0])
      `CHK({ctl.flash_pd, ctl.bg_off, ctl.reg_mode}, {1'b1, i[0], REG_ULP})
      ev_lines <= i ? 20'h20 : 20'h8;
      repeat (10) @(posedge clk);
      `CHK(ctl.cpu_clk_en, 1'b0)
      ev_lines <= i ? 20'h20000 : 20'h20;
      lat = OSC_START_CYC + REG_RECOV_CYC + LP_EXTRA_CYC + (i ? BG_RECOV_CYC : 0);
      if (i == 0 && lat < 1500) lat = 1500;
      wait_cpu(1'b1);
      `CHK(n >= lat && n <= lat + 20, 1'b1)
      ev_lines <= '0;
      repeat (2) @(posedge clk);
      `CHK(ctl.sysclk_sel, SEL_MED)
      `CHK(cfg_cnt - c, 1)
      bus(1'b0, OFS_STATUS, 0);
      `CHK(q[ST_CKF], 1'b1)
    end
    bus(1'b1, OFS_MODE, 32'h1A);
    bus(1'b0, OFS_MODE, 0);
    `CHK(q[MD_WDGKEY], 1'b1)
    bus(1'b1, OFS_CTRL_ZERO, 32'h40);
    bus(1'b0, OFS_CTRL_ZERO, 0);
    `CHK(q[6:5], TSEL_STANDBY)
    tamper <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, OFS_STATUS, 32'h7);
      c = sr_cnt;
      pulse(j[0]);
      wait_cpu(1'b0);
      repeat (3) @(posedge clk);
      if (j == 0) begin
        `CHK({ctl.io_hiz, ctl.wake_pad_keep, ctl.tamper_pad_keep}, 3'h7)
        `CHK({ctl.core_on, ctl.medium_osc_en, ctl.hs_clk_allow}, 3'h0)
        `CHK({ctl.reg_mode, ctl.flash_pd}, {REG_ULP, 1'b1})
        `CHK({ctl.bg_off, ctl.reset_bandgap_off, ctl.sram_off, ctl.vdet_off}, 5'h1F)
        `CHK(ctl.watchdog_run, 1'b1)
      end
      case (j)
        0: wpin <= 1'b1;
        1: alarm <= 1'b1;
        2: rpin_n <= 1'b0;
        default: wdg_rst <= 1'b1;
      endcase
      repeat (4) @(posedge clk);
      {wpin, alarm, wdg_rst} <= 3'h0;
      rpin_n <= 1'b1;
      wait_cpu(1'b1);
      repeat (2) @(posedge clk);
      `CHK(sr_cnt - c, 1)
      `CHK(ctl.fast_osc_en, 1'b0)
      bus(1'b0, OFS_STATUS, 0);
      `CHK(q[2:1], 2'h3)
    end
    pulse(1'b1);
    repeat (3) @(posedge clk);
    `CHK(ctl.cpu_clk_en, 1'b1)
    bus(1'b1, OFS_CTRL_ZERO, 32'h20);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    `CHK({ctl.cpu_clk_en, ctl.medium_osc_en, ctl.hs_clk_allow}, 3'h3)
    core.irq_pending <= 1'b1;
    wait_cpu(1'b1);
    core.irq_pending <= 1'b0;
    tally_and_finish();
  end
endmodule : low_power_mode_controller_tb
`default_nettype wire
